/* File: core_model.sv */
// Processor core stand-in: interrupt window and program counter source
`timescale 1ns/1ps
module core_model (
  input  wire logic        clk,            // Core clock
  input  wire logic        pc_load,        // Vector load strobe
  output logic             instr_boundary, // Core ready to take interrupts
  output logic [15:0]      pc_current      // Address of next instruction
);
  // Always at an instruction boundary, start somewhere in code space
  initial begin
    instr_boundary = 1'b1;
    pc_current = 16'h1234;
  end
  // Jump to a fresh address after each vector load
  always @(posedge clk) if (pc_load) pc_current <= 16'($urandom);
endmodule // core_model

/* File: first_request_pick.sv */
// Fixed-order picker: finds the lowest-numbered active request
`timescale 1ns/1ps
module first_request_pick #(
  parameter int N = 11,
  parameter int W = 4
) (
  input  wire logic [N-1:0] req,   // Requests, bit 0 first
  output logic              any,   // At least one request
  output logic [W-1:0]      idx    // Index of first request
);

  // ************************************************************
  // Scan from last to first so the first one wins
  // ************************************************************
  always_comb begin
    idx = '0;
    for (int i = N - 1; i >= 0; i--) begin
      if (req[i]) begin
        idx = W'(i); // [RQ11]
      end
    end
  end

  // Any request present
  assign any = |req;

endmodule // first_request_pick

/* File: irq_ctrl_pkg.sv */
// Constants, register map and types for the two-level interrupt controller
// Contract
// [RQ1] Enable bit 7 gates every maskable source
// [RQ2] Primary enable holds seven per-source enables
// [RQ3] Primary level register picks high or low
// [RQ4] Secondary enables: interval, supply monitor, serial
// [RQ5] Secondary levels at bits six to four
// [RQ6] Software keeps secondary bit three at zero
// [RQ7] Reset values 00H, 00H, A0H; bit access
// [RQ8] High request preempts a low service routine
// [RQ9] Simultaneous levels: high served before low
// [RQ10] Same level never preempts a running routine
// [RQ11] Fixed polling order within one level
// [RQ12] Program counter pushed before the redirect
// [RQ13] Program counter loaded with fixed source vector
// [RQ14] Watchdog interrupt mode replaces watchdog reset
// [RQ15] Watchdog request is always high level
// [RQ16] Global enable never masks the watchdog
// [RQ17] Watchdog interrupts only with nonzero timeout
// [RQ18] Shared-vector flags are ORed into one
// [RQ19] Active level released by return from interrupt
package irq_ctrl_pkg;

  // ************************************************************
  // Register addresses and reset values
  // ************************************************************
  localparam logic [7:0] ADDR_ENABLE_PRIMARY    = 8'hA8; // Bit addressable
  localparam logic [7:0] ADDR_ENABLE_LEVEL_SEC  = 8'hA9; // Byte access only
  localparam logic [7:0] ADDR_LEVEL_PRIMARY     = 8'hB8; // Bit addressable
  localparam logic [7:0] RESET_ENABLE_PRIMARY   = 8'h00;
  localparam logic [7:0] RESET_ENABLE_LEVEL_SEC = 8'hA0;
  localparam logic [7:0] RESET_LEVEL_PRIMARY    = 8'h00;
  localparam logic [7:0] LEVEL_PRIMARY_RD_MASK  = 8'h7F; // Reserved top bit reads 0

  // ************************************************************
  // Field positions
  // ************************************************************
  localparam int GLOBAL_IRQ_ENABLE_BIT  = 7;
  localparam int ADC_IRQ_ENABLE_BIT     = 6;
  localparam int TIMER2_IRQ_ENABLE_BIT  = 5;
  localparam int UART_IRQ_ENABLE_BIT    = 4;
  localparam int TIMER1_IRQ_ENABLE_BIT  = 3;
  localparam int EXT1_IRQ_ENABLE_BIT    = 2;
  localparam int TIMER0_IRQ_ENABLE_BIT  = 1;
  localparam int EXT0_IRQ_ENABLE_BIT    = 0;
  localparam int ADC_IRQ_LEVEL_BIT      = 6;
  localparam int TIMER2_IRQ_LEVEL_BIT   = 5;
  localparam int UART_IRQ_LEVEL_BIT     = 4;
  localparam int TIMER1_IRQ_LEVEL_BIT   = 3;
  localparam int EXT1_IRQ_LEVEL_BIT     = 2;
  localparam int TIMER0_IRQ_LEVEL_BIT   = 1;
  localparam int EXT0_IRQ_LEVEL_BIT     = 0;
  localparam int INTERVAL_LEVEL_BIT     = 6;
  localparam int SUPPLY_LEVEL_BIT       = 5;
  localparam int SERIAL_LEVEL_BIT       = 4;
  localparam int INTERVAL_ENABLE_BIT    = 2;
  localparam int SUPPLY_ENABLE_BIT      = 1;
  localparam int SERIAL_ENABLE_BIT      = 0;

  // ************************************************************
  // Sources in polling order, first is served first
  // ************************************************************
  localparam int NUM_SRC   = 11;
  localparam int SRC_SUPPLY   = 0;
  localparam int SRC_WDOG     = 1;
  localparam int SRC_EXT0     = 2;
  localparam int SRC_ADC      = 3;
  localparam int SRC_TIMER0   = 4;
  localparam int SRC_EXT1     = 5;
  localparam int SRC_TIMER1   = 6;
  localparam int SRC_SERIAL   = 7;
  localparam int SRC_UART     = 8;
  localparam int SRC_TIMER2   = 9;
  localparam int SRC_INTERVAL = 10;

  // Vector address per source, indexed in polling order
  localparam logic [15:0] VECTOR_ADDR [0:NUM_SRC-1] = '{
    16'h0043, 16'h005B, 16'h0003, 16'h0033, 16'h000B, 16'h0013,
    16'h001B, 16'h003B, 16'h0023, 16'h002B, 16'h0053};

  // ************************************************************
  // Vectoring sequence states
  // ************************************************************
  typedef enum logic [1:0] {
    ST_IDLE    = 2'b00,
    ST_PUSH_LO = 2'b01,
    ST_PUSH_HI = 2'b10,
    ST_LOAD    = 2'b11
  } vec_state_t;

endpackage

/* File: two_level_interrupt_controller.sv */
// Two-level interrupt controller with register file and vectoring sequence
`timescale 1ns/1ps
module two_level_interrupt_controller (
  input  wire logic        clk,                  // Core clock
  input  wire logic        arst_n,               // Async reset, low active
  input  wire logic        ce,                   // Clock enable, freezes state
  // Register port
  input  wire logic [7:0]  sfr_addr,             // Byte register address
  input  wire logic        sfr_wr,               // Byte write strobe
  input  wire logic        sfr_rd,               // Byte read strobe
  input  wire logic [7:0]  sfr_wdata,            // Byte write data
  output logic [7:0]       sfr_rdata,            // Read data, registered
  output logic             sfr_hit,              // Address is ours
  input  wire logic [7:0]  bit_addr,             // Bit address
  input  wire logic        bit_wr,               // Bit write strobe
  input  wire logic        bit_wdata,            // Bit value
  // Peripheral flags
  input  wire logic        supply_monitor_flag,
  input  wire logic        watchdog_irq_flag,
  input  wire logic        watchdog_irq_mode,
  input  wire logic [3:0]  watchdog_timeout_sel, // Zero means no timeout
  input  wire logic        ext0_request_flag,
  input  wire logic        ext1_request_flag,
  input  wire logic        main_adc_ready_flag,
  input  wire logic        aux_adc_ready_flag,
  input  wire logic        timer0_overflow_flag,
  input  wire logic        timer1_overflow_flag,
  input  wire logic        timer2_overflow_flag,
  input  wire logic        timer2_external_flag,
  input  wire logic        spi_request_flag,
  input  wire logic        twowire_request_flag,
  input  wire logic        uart_receive_flag,
  input  wire logic        uart_transmit_flag,
  input  wire logic        interval_counter_flag,
  // Core side
  input  wire logic        instr_boundary,       // Core may take an interrupt
  input  wire logic        reti,                 // Return from interrupt pulse
  input  wire logic [15:0] pc_current,           // Program counter to save
  output logic             irq_pending,          // Serviceable request waits
  output logic             stack_push,           // Push stack_data this cycle
  output logic [7:0]       stack_data,           // Byte to push
  output logic             pc_load,              // Load pc_value this cycle
  output logic [15:0]      pc_value,             // Vector address
  output logic [10:0]      irq_taken,            // One-cycle pulse per source
  output logic             watchdog_reset_req,   // Watchdog resets device
  output logic             active_high,          // High routine running
  output logic             active_low            // Low routine running
);

  // ************************************************************
  // Register file
  // ************************************************************
  logic [7:0] interrupt_enable_primary;            // Enables and global bit
  logic [7:0] interrupt_enable_priority_secondary; // Secondary enables/levels
  logic [7:0] interrupt_level_primary;             // Primary levels

  // Address decode
  wire sel_en_pri  = (sfr_addr == irq_ctrl_pkg::ADDR_ENABLE_PRIMARY);
  wire sel_sec     = (sfr_addr == irq_ctrl_pkg::ADDR_ENABLE_LEVEL_SEC);
  wire sel_lvl_pri = (sfr_addr == irq_ctrl_pkg::ADDR_LEVEL_PRIMARY);
  assign sfr_hit = sel_en_pri | sel_sec | sel_lvl_pri;

  // Bit writes only reach the two bit-addressable registers
  wire bit_en_pri  = bit_wr && (bit_addr[7:3] == irq_ctrl_pkg::ADDR_ENABLE_PRIMARY[7:3]);
  wire bit_lvl_pri = bit_wr && (bit_addr[7:3] == irq_ctrl_pkg::ADDR_LEVEL_PRIMARY[7:3]);

  // Bit write merge value per register
  wire [7:0] bit_mask      = 8'h01 << bit_addr[2:0];
  wire [7:0] en_pri_bitval = bit_wdata ? (interrupt_enable_primary | bit_mask)
                                       : (interrupt_enable_primary & ~bit_mask);
  wire [7:0] lvl_pri_bitval = bit_wdata ? (interrupt_level_primary | bit_mask)
                                        : (interrupt_level_primary & ~bit_mask);

  // Next register values, byte write wins over bit write
  wire [7:0] next_en_pri = (sfr_wr && sel_en_pri) ? sfr_wdata :
                           bit_en_pri ? en_pri_bitval : interrupt_enable_primary;
  wire [7:0] next_lvl_pri = (sfr_wr && sel_lvl_pri) ? sfr_wdata :
                            bit_lvl_pri ? lvl_pri_bitval : interrupt_level_primary;
  wire [7:0] next_sec = (sfr_wr && sel_sec) ? sfr_wdata
                                            : interrupt_enable_priority_secondary;

  // Register storage with documented reset values
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      interrupt_enable_primary            <= irq_ctrl_pkg::RESET_ENABLE_PRIMARY;   // RQ7
      interrupt_enable_priority_secondary <= irq_ctrl_pkg::RESET_ENABLE_LEVEL_SEC; // RQ7
      interrupt_level_primary             <= irq_ctrl_pkg::RESET_LEVEL_PRIMARY;    // RQ7
    end else if (ce) begin
      interrupt_enable_primary            <= next_en_pri;
      interrupt_enable_priority_secondary <= next_sec;
      interrupt_level_primary             <= next_lvl_pri;
    end
  end

  // Read mux, reserved top bit of primary levels reads zero
  wire [7:0] rd_mux = sel_en_pri  ? interrupt_enable_primary :
                      sel_sec     ? interrupt_enable_priority_secondary :
                      sel_lvl_pri ? (interrupt_level_primary &
                                     irq_ctrl_pkg::LEVEL_PRIMARY_RD_MASK) : 8'h00;

  // Registered read data
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      sfr_rdata <= 8'h00;
    end else if (ce && sfr_rd) begin
      sfr_rdata <= rd_mux;
    end
  end

  // ************************************************************
  // Source requests, enables and levels in polling order
  // ************************************************************
  wire global_irq_enable = interrupt_enable_primary[irq_ctrl_pkg::GLOBAL_IRQ_ENABLE_BIT];
  wire wdog_req = watchdog_irq_flag && watchdog_irq_mode && // RQ14
                  (watchdog_timeout_sel != 4'h0);           // RQ17
  assign watchdog_reset_req = watchdog_irq_flag && !watchdog_irq_mode; // RQ14

  logic [10:0] raw_req; // Raw requests
  logic [10:0] src_en;  // Per-source enables
  logic [10:0] src_lvl; // One means high level

  // Shared-vector flags combine into one request
  assign raw_req[irq_ctrl_pkg::SRC_SUPPLY]   = supply_monitor_flag;
  assign raw_req[irq_ctrl_pkg::SRC_WDOG]     = wdog_req;
  assign raw_req[irq_ctrl_pkg::SRC_EXT0]     = ext0_request_flag;
  assign raw_req[irq_ctrl_pkg::SRC_ADC]      = main_adc_ready_flag | aux_adc_ready_flag; // RQ18
  assign raw_req[irq_ctrl_pkg::SRC_TIMER0]   = timer0_overflow_flag;
  assign raw_req[irq_ctrl_pkg::SRC_EXT1]     = ext1_request_flag;
  assign raw_req[irq_ctrl_pkg::SRC_TIMER1]   = timer1_overflow_flag;
  assign raw_req[irq_ctrl_pkg::SRC_SERIAL]   = spi_request_flag | twowire_request_flag; // RQ18
  assign raw_req[irq_ctrl_pkg::SRC_UART]     = uart_receive_flag | uart_transmit_flag; // RQ18
  assign raw_req[irq_ctrl_pkg::SRC_TIMER2]   = timer2_overflow_flag | timer2_external_flag; // RQ18
  assign raw_req[irq_ctrl_pkg::SRC_INTERVAL] = interval_counter_flag;

  // Enables: global bit gates all but the watchdog
  assign src_en[irq_ctrl_pkg::SRC_SUPPLY] = global_irq_enable && // RQ1
    interrupt_enable_priority_secondary[irq_ctrl_pkg::SUPPLY_ENABLE_BIT]; // RQ4
  assign src_en[irq_ctrl_pkg::SRC_WDOG] = 1'b1; // RQ16
  assign src_en[irq_ctrl_pkg::SRC_EXT0] = global_irq_enable &&
    interrupt_enable_primary[irq_ctrl_pkg::EXT0_IRQ_ENABLE_BIT]; // RQ2
  assign src_en[irq_ctrl_pkg::SRC_ADC] = global_irq_enable &&
    interrupt_enable_primary[irq_ctrl_pkg::ADC_IRQ_ENABLE_BIT]; // RQ2
  assign src_en[irq_ctrl_pkg::SRC_TIMER0] = global_irq_enable &&
    interrupt_enable_primary[irq_ctrl_pkg::TIMER0_IRQ_ENABLE_BIT]; // RQ2
  assign src_en[irq_ctrl_pkg::SRC_EXT1] = global_irq_enable &&
    interrupt_enable_primary[irq_ctrl_pkg::EXT1_IRQ_ENABLE_BIT]; // RQ2
  assign src_en[irq_ctrl_pkg::SRC_TIMER1] = global_irq_enable &&
    interrupt_enable_primary[irq_ctrl_pkg::TIMER1_IRQ_ENABLE_BIT]; // RQ2
  assign src_en[irq_ctrl_pkg::SRC_SERIAL] = global_irq_enable &&
    interrupt_enable_priority_secondary[irq_ctrl_pkg::SERIAL_ENABLE_BIT]; // RQ4
  assign src_en[irq_ctrl_pkg::SRC_UART] = global_irq_enable &&
    interrupt_enable_primary[irq_ctrl_pkg::UART_IRQ_ENABLE_BIT]; // RQ2
  assign src_en[irq_ctrl_pkg::SRC_TIMER2] = global_irq_enable &&
    interrupt_enable_primary[irq_ctrl_pkg::TIMER2_IRQ_ENABLE_BIT]; // RQ2
  assign src_en[irq_ctrl_pkg::SRC_INTERVAL] = global_irq_enable &&
    interrupt_enable_priority_secondary[irq_ctrl_pkg::INTERVAL_ENABLE_BIT]; // RQ4

  // Levels: watchdog is fixed high
  assign src_lvl[irq_ctrl_pkg::SRC_SUPPLY] =
    interrupt_enable_priority_secondary[irq_ctrl_pkg::SUPPLY_LEVEL_BIT]; // RQ5
  assign src_lvl[irq_ctrl_pkg::SRC_WDOG] = 1'b1; // RQ15
  assign src_lvl[irq_ctrl_pkg::SRC_EXT0] =
    interrupt_level_primary[irq_ctrl_pkg::EXT0_IRQ_LEVEL_BIT]; // RQ3
  assign src_lvl[irq_ctrl_pkg::SRC_ADC] =
    interrupt_level_primary[irq_ctrl_pkg::ADC_IRQ_LEVEL_BIT]; // RQ3
  assign src_lvl[irq_ctrl_pkg::SRC_TIMER0] =
    interrupt_level_primary[irq_ctrl_pkg::TIMER0_IRQ_LEVEL_BIT]; // RQ3
  assign src_lvl[irq_ctrl_pkg::SRC_EXT1] =
    interrupt_level_primary[irq_ctrl_pkg::EXT1_IRQ_LEVEL_BIT]; // RQ3
  assign src_lvl[irq_ctrl_pkg::SRC_TIMER1] =
    interrupt_level_primary[irq_ctrl_pkg::TIMER1_IRQ_LEVEL_BIT]; // RQ3
  assign src_lvl[irq_ctrl_pkg::SRC_SERIAL] =
    interrupt_enable_priority_secondary[irq_ctrl_pkg::SERIAL_LEVEL_BIT]; // RQ5
  assign src_lvl[irq_ctrl_pkg::SRC_UART] =
    interrupt_level_primary[irq_ctrl_pkg::UART_IRQ_LEVEL_BIT]; // RQ3
  assign src_lvl[irq_ctrl_pkg::SRC_TIMER2] =
    interrupt_level_primary[irq_ctrl_pkg::TIMER2_IRQ_LEVEL_BIT]; // RQ3
  assign src_lvl[irq_ctrl_pkg::SRC_INTERVAL] =
    interrupt_enable_priority_secondary[irq_ctrl_pkg::INTERVAL_LEVEL_BIT]; // RQ5

  // Requests split by level
  wire [10:0] hi_req = raw_req & src_en & src_lvl;
  wire [10:0] lo_req = raw_req & src_en & ~src_lvl;

  // ************************************************************
  // Polling within each level
  // ************************************************************
  logic       hi_any; // High request present
  logic [3:0] hi_idx; // First high request
  logic       lo_any; // Low request present
  logic [3:0] lo_idx; // First low request

  first_request_pick #(.N(11), .W(4)) u_pick_hi (
    .req (hi_req),
    .any (hi_any),
    .idx (hi_idx)
  );

  first_request_pick #(.N(11), .W(4)) u_pick_lo (
    .req (lo_req),
    .any (lo_any),
    .idx (lo_idx)
  );

  // ************************************************************
  // Nesting and acceptance
  // ************************************************************
  irq_ctrl_pkg::vec_state_t state;      // Vectoring sequence state
  irq_ctrl_pkg::vec_state_t next_state; // Next sequence state
  logic [15:0]              saved_pc;   // Program counter to push

  // High may preempt low but never another high
  wire hi_serviceable = hi_any && !active_high;                 // RQ8 RQ10
  wire lo_serviceable = lo_any && !active_high && !active_low;  // RQ10
  assign irq_pending = hi_serviceable || lo_serviceable;

  // Accept only at an instruction boundary while idle
  wire take_ok    = ce && (state == irq_ctrl_pkg::ST_IDLE) && instr_boundary;
  wire accept_hi  = take_ok && hi_serviceable;                  // RQ9
  wire accept_lo  = take_ok && !hi_serviceable && lo_serviceable; // RQ9
  wire accept     = accept_hi || accept_lo;
  wire [3:0] taken_idx = accept_hi ? hi_idx : lo_idx;

  // Active level tracking, taking a level wins over release
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      active_high <= 1'b0;
      active_low  <= 1'b0;
    end else if (ce) begin
      if (accept_hi) begin
        active_high <= 1'b1;
      end else if (reti && active_high) begin
        active_high <= 1'b0; // RQ19
      end
      if (accept_lo) begin
        active_low <= 1'b1;
      end else if (reti && !active_high) begin
        active_low <= 1'b0; // RQ19
      end
    end
  end

  // ************************************************************
  // Vectoring sequence: push low, push high, load vector
  // ************************************************************
  always_comb begin
    case (state)
      irq_ctrl_pkg::ST_IDLE: begin
        next_state = accept ? irq_ctrl_pkg::ST_PUSH_LO : irq_ctrl_pkg::ST_IDLE;
      end
      irq_ctrl_pkg::ST_PUSH_LO: begin
        next_state = irq_ctrl_pkg::ST_PUSH_HI; // RQ12
      end
      irq_ctrl_pkg::ST_PUSH_HI: begin
        next_state = irq_ctrl_pkg::ST_LOAD; // RQ12
      end
      irq_ctrl_pkg::ST_LOAD: begin
        next_state = irq_ctrl_pkg::ST_IDLE;
      end
      default: begin
        next_state = irq_ctrl_pkg::ST_IDLE;
      end
    endcase
  end

  // State register
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state <= irq_ctrl_pkg::ST_IDLE;
    end else if (ce) begin
      state <= next_state;
    end
  end

  // Sequence strobes decode from state
  assign stack_push = (state == irq_ctrl_pkg::ST_PUSH_LO) ||
                      (state == irq_ctrl_pkg::ST_PUSH_HI);
  assign pc_load    = (state == irq_ctrl_pkg::ST_LOAD);

  // Captured program counter, vector and push byte
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      saved_pc   <= 16'h0000;
      pc_value   <= 16'h0000;
      stack_data <= 8'h00;
    end else if (ce) begin
      if (accept) begin
        saved_pc   <= pc_current;
        pc_value   <= irq_ctrl_pkg::VECTOR_ADDR[taken_idx]; // RQ13
        stack_data <= pc_current[7:0];                      // RQ12
      end else if (state == irq_ctrl_pkg::ST_PUSH_LO) begin
        stack_data <= saved_pc[15:8];                       // RQ12
      end
    end
  end

  // One-cycle pulse naming the source taken
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      irq_taken <= 11'h000;
    end else if (ce) begin
      irq_taken <= accept ? (11'h001 << taken_idx) : 11'h000;
    end
  end

  // ************************************************************
  // Assertions
  // ************************************************************
  global_mask_a: assert property (@(posedge clk) disable iff (!arst_n) // RQ1
    (accept && !global_irq_enable) |-> (taken_idx == 4'(irq_ctrl_pkg::SRC_WDOG)))
    else $error("maskable source taken with global enable off");

  wdog_unmasked_a: assert property (@(posedge clk) disable iff (!arst_n) // RQ16
    (take_ok && !active_high && wdog_req && !raw_req[irq_ctrl_pkg::SRC_SUPPLY])
    |-> (accept_hi && hi_idx == 4'(irq_ctrl_pkg::SRC_WDOG)))
    else $error("watchdog request not taken");

  high_first_a: assert property (@(posedge clk) disable iff (!arst_n) // RQ9
    (take_ok && hi_any && !active_high) |-> accept_hi)
    else $error("low request served before high");

  same_level_a: assert property (@(posedge clk) disable iff (!arst_n) // RQ10
    (active_low && accept) |-> accept_hi)
    else $error("low routine preempted by low request");

  preempt_low_a: assert property (@(posedge clk) disable iff (!arst_n) // RQ8
    (take_ok && active_low && !active_high && hi_any) |=> (active_high && stack_push))
    else $error("high request did not preempt low routine");

  poll_order_a: assert property (@(posedge clk) disable iff (!arst_n) // RQ11
    (accept_hi && hi_req[irq_ctrl_pkg::SRC_SUPPLY]) |-> (taken_idx == 4'h0))
    else $error("polling order violated");

  push_seq_a: assert property (@(posedge clk) disable iff (!arst_n) // RQ12
    accept |=> (stack_push && !pc_load && stack_data == saved_pc[7:0]))
    else $error("program counter not pushed in order");

  push_high_a: assert property (@(posedge clk) disable iff (!arst_n) // RQ12
    (state == irq_ctrl_pkg::ST_PUSH_HI) |-> (stack_push && stack_data == saved_pc[15:8]))
    else $error("high program counter byte not pushed second");

  vector_a: assert property (@(posedge clk) disable iff (!arst_n) // RQ13
    accept |=> (pc_value == irq_ctrl_pkg::VECTOR_ADDR[$past(taken_idx)]))
    else $error("wrong vector loaded");

  wdog_mode_a: assert property (@(posedge clk) disable iff (!arst_n) // RQ14
    watchdog_irq_flag |-> (watchdog_reset_req != watchdog_irq_mode))
    else $error("watchdog mode does not choose reset or interrupt");

  wdog_zero_a: assert property (@(posedge clk) disable iff (!arst_n) // RQ17
    (watchdog_timeout_sel == 4'h0) |-> !hi_req[irq_ctrl_pkg::SRC_WDOG])
    else $error("watchdog interrupt with zero timeout");

  level_release_a: assert property (@(posedge clk) disable iff (!arst_n) // RQ19
    (ce && reti && active_high && !accept_hi) |=> (!active_high && $stable(active_low)))
    else $error("return did not release the high level");

endmodule // two_level_interrupt_controller

/* File: two_level_interrupt_controller_test.sv */
// Self-checking bench for the two-level interrupt controller
`timescale 1ns/1ps
module two_level_interrupt_controller_test;
  logic clk = 0, arst_n = 0, ce = 1, sfr_wr = 0, sfr_rd = 0, bit_wr = 0, bit_wdata = 0, reti = 0;
  logic [7:0] sfr_addr = 0, sfr_wdata = 0, bit_addr = 0, sfr_rdata, stack_data, ie, ip, s2;
  logic [14:0] f = 0, fl;          // Peripheral flags
  logic md = 0, instr_boundary, stack_push, pc_load, watchdog_reset_req, active_high, active_low;
  logic [3:0] ts = 0;
  logic sfr_hit, irq_pending;
  logic [15:0] pc_current, pc_value;
  logic [10:0] irq_taken, rq, en, hl;
  int fail_count = 0, num_checks = 0, ah = 0, al = 0, b, lv, a, n;
  // Vector per source in polling order
  logic [15:0] vec [11] = '{16'h0043, 16'h005B, 16'h0003, 16'h0033, 16'h000B, 16'h0013,
                            16'h001B, 16'h003B, 16'h0023, 16'h002B, 16'h0053};
  two_level_interrupt_controller two_level_interrupt_controller_inst (.clk, .arst_n, .ce,
    .sfr_addr, .sfr_wr, .sfr_rd, .sfr_wdata, .sfr_rdata, .sfr_hit, .bit_addr, .bit_wr,
    .bit_wdata, .supply_monitor_flag(f[0]), .watchdog_irq_flag(f[1]), .watchdog_irq_mode(md),
    .watchdog_timeout_sel(ts), .ext0_request_flag(f[2]), .ext1_request_flag(f[6]),
    .main_adc_ready_flag(f[3]), .aux_adc_ready_flag(f[4]), .timer0_overflow_flag(f[5]),
    .timer1_overflow_flag(f[7]), .timer2_overflow_flag(f[12]), .timer2_external_flag(f[13]),
    .spi_request_flag(f[8]), .twowire_request_flag(f[9]), .uart_receive_flag(f[10]),
    .uart_transmit_flag(f[11]), .interval_counter_flag(f[14]), .instr_boundary, .reti,
    .pc_current, .irq_pending, .stack_push, .stack_data, .pc_load, .pc_value, .irq_taken,
    .watchdog_reset_req, .active_high, .active_low);
  core_model core_model_inst (.clk, .pc_load, .instr_boundary, .pc_current);
  initial forever #25 clk = ~clk;
  // Compare and count
  task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
    num_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic wr(input logic [7:0] ad, input logic [7:0] d);
    @(posedge clk) {sfr_addr, sfr_wdata, sfr_wr} <= {ad, d, 1'b1};
    @(posedge clk) sfr_wr <= 0;
  endtask
  task automatic rd(input logic [7:0] ad, input logic [7:0] exp);
    @(posedge clk) {sfr_addr, sfr_rd} <= {ad, 1'b1};
    @(posedge clk) sfr_rd <= 0;
    #1 chk("read data", exp, sfr_rdata);
    chk("address hit", 16'(ad inside {8'hA8, 8'hA9, 8'hB8}), 16'(sfr_hit));
  endtask
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  initial begin
    void'($urandom(58));
    repeat (12) @(posedge clk);
    arst_n <= 1;
    rd(8'hA8, 8'h00); rd(8'hA9, 8'hA0); rd(8'hB8, 8'h00); rd(8'hA0, 8'h00);
    wr(8'hB8, 8'hFF); rd(8'hB8, 8'h7F);
    @(posedge clk) {bit_addr, bit_wdata, bit_wr} <= {8'hAF, 2'b11};
    @(posedge clk) {bit_addr, bit_wdata, bit_wr} <= {8'hB8, 2'b01};
    @(posedge clk) bit_wr <= 0;
    rd(8'hA8, 8'h80); rd(8'hB8, 8'h7E);
    @(posedge clk) ce <= 0;
    wr(8'hA8, 8'h55);
    ce <= 1;
    rd(8'hA8, 8'h80);
    $display("test registers done");
    repeat (80) begin
      ie = 8'($urandom); ip = 8'($urandom); s2 = 8'($urandom) & 8'hF7;
      fl = 15'($urandom & $urandom);
      wr(8'hA8, ie); wr(8'hB8, ip); wr(8'hA9, s2);
      @(posedge clk) {f, md, ts} <= {fl, 5'($urandom)};
      #1 chk("reset request", 16'(fl[1] & ~md), 16'(watchdog_reset_req));
      rq = {fl[14], fl[12] | fl[13], fl[10] | fl[11], fl[8] | fl[9], fl[7], fl[6], fl[5],
            fl[3] | fl[4], fl[2], fl[1] & md & (ts != 0), fl[0]};
      en = {s2[2], ie[5], ie[4], s2[0], ie[3], ie[2], ie[1], ie[6], ie[0], 1'b1, s2[1]}
           & {{9{ie[7]}}, 1'b1, ie[7]};
      hl = {s2[6], ip[5], ip[4], s2[4], ip[3], ip[2], ip[1], ip[6], ip[0], 1'b1, s2[5]};
      a = ah ? 2 : al;
      b = -1;
      for (int l = 1; l >= 0; l--) if (b < 0 && l >= a) for (int i = 10; i >= 0; i--) begin
        if (rq[i] & en[i] & (hl[i] == l)) {b, lv} = {i, l};
      end
      chk("pending", 16'(b >= 0), 16'(irq_pending));
      for (n = 0; n < 8 && stack_push !== 1'b1; n++) @(posedge clk) #1;
      chk("vectoring", 16'(b >= 0), 16'(stack_push));
      if (b >= 0 && stack_push !== 1'b1) give_verdict;
      if (stack_push === 1'b1 && b >= 0) begin
        chk("taken source", 16'(1 << b), 16'(irq_taken));
        chk("push low", 16'(pc_current[7:0]), 16'(stack_data));
        @(posedge clk) f <= 0;
        #1 chk("push high", 16'(pc_current[15:8]), 16'(stack_data));
        @(posedge clk) #1 chk("load", 16'h0001, 16'(pc_load));
        chk("vector", vec[b], pc_value);
        if (lv) ah = 1; else al = 1;
      end else @(posedge clk) f <= 0;
      if ($urandom % 2) begin
        @(posedge clk) reti <= 1;
        @(posedge clk) reti <= 0;
        if (ah) ah = 0; else al = 0;
      end
      #1 chk("active level", 16'({ah[0], al[0]}), 16'({active_high, active_low}));
      $display("test vectoring source %0d done", b);
    end
    @(posedge clk) arst_n <= 0;
    @(posedge clk) arst_n <= 1;
    rd(8'hA9, 8'hA0); rd(8'hA8, 8'h00);
    chk("reset level", 16'h0000, 16'({active_high, active_low}));
    $display("test second reset done");
    give_verdict;
  end
endmodule // two_level_interrupt_controller_test
